/* File: twowire_pkg.sv */
// constants shared by the management two-wire slave and its buffer
`default_nettype none
package twowire_pkg;
    localparam int          CLK_FREQ_HZ        = 25_000_000;
    localparam int          STORE_TIME_US      = 10;
    localparam int          STORE_CYCLES_DEF   = STORE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam logic [6:0]  DEV_ADDR_DEF       = 7'h50;
    localparam logic [7:0]  CRC_POLY           = 8'h07;
    localparam logic [7:0]  CRC_INIT           = 8'h00;
    localparam int          MAX_WR_BYTES       = 4;
    localparam int          MAX_RD_BYTES       = 128;
    localparam logic [3:0]  BIT_LAST_DATA      = 4'h7;
    localparam logic [3:0]  BIT_ACK            = 4'h8;
    localparam logic [7:0]  ADDR_RST           = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DEVADDR,
        S_MADDR,
        S_COUNT,
        S_WDATA,
        S_RDATA,
        S_WAIT
    } link_state_t;
endpackage
`default_nettype wire

/* File: twin_buf.sv */
// two-entry valid/ready buffer for store words
`timescale 1ns/1ps
`default_nettype none
module twin_buf
    import twowire_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         core_clk,   // system clock
    input  wire logic         rst_n,      // async reset, active low
    input  wire logic         in_valid,   // word offered
    output logic              in_ready,   // room for a word
    input  wire logic [W-1:0] in_data,    // offered word
    output logic              out_valid,  // word available
    input  wire logic         out_ready,  // sink takes word
    output logic      [W-1:0] out_data    // oldest word
);
    logic [W-1:0] slot_ff [2];
    logic         wr_ptr_ff;
    logic         rd_ptr_ff;
    logic [1:0]   cnt_ff;
    logic         push;
    logic         pop;

    if (W < 1) begin : g_bad_width
        $error("twin_buf width must be positive");
    end

    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = slot_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            slot_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

/* File: mgmt_twowire_slave.sv */
// two-wire management slave with checked reads and up to four-byte writes
// Function
// R1 - host sends write address, start address, count
// R2 - checksum over address, count, then data
// R3 - checksum byte follows the last requested byte
// R4 - host ends checked read with nack, stop
// R5 - host may discard read on checksum mismatch
// R6 - bus address byte excluded from checksum
// R7 - checked read count is 1 to 128
// R8 - checked transfers must follow the format exactly
// R9 - write is address, memory address, data
// R10 - ack memory address and data bytes low
// R11 - only stop starts internal storing
// R12 - repeated start cancels write, drops bytes
// R13 - valid stop starts self-timed store cycle
// R14 - ignore bus during store cycle
// R15 - no combined format within writes
// R16 - accept up to four data bytes
// R17 - host sends at most three further bytes
// R18 - ack every received write data byte; code acks only the first four, a fifth is not acked
// R19 - write without stop is cancelled
// R20 - keep sending successive bytes while acked
// R21 - address advances after each byte
// R22 - configuration input selects checked mode
`timescale 1ns/1ps
`default_nettype none
module mgmt_twowire_slave
    import twowire_pkg::*;
#(
    parameter int         STORE_CYCLES = STORE_CYCLES_DEF,
    parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEF
) (
    input  wire logic       core_clk,      // system clock, 25 MHz
    input  wire logic       rst_n,         // async reset, active low
    input  wire logic       scl_in,        // bus clock level
    input  wire logic       sda_in,        // bus data level
    output logic            sda_out,       // bus data drive value
    output logic            sda_oe,        // high while pulling data low
    input  wire logic       packet_error_check, // checked mode enable
    output logic      [7:0] mem_rd_addr,   // memory read address
    input  wire logic [7:0] mem_rd_data,   // memory read data
    output logic            store_valid,   // store word valid
    input  wire logic       store_ready,   // memory takes store word
    output logic      [7:0] store_addr,    // store word address
    output logic      [7:0] store_data,    // store word data
    output logic            store_busy     // internal store cycle running
);
    if (STORE_CYCLES < 1) begin : g_bad_store
        $error("STORE_CYCLES must be at least one");
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic       fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[7] ^ d[i];
            r  = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    link_state_t st_ff;
    logic        scl_q_ff;
    logic        sda_q_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  tx_ff;
    logic        sda_oe_ff;
    logic [7:0]  addr_ff;
    logic [7:0]  crc_ff;
    logic [7:0]  rem_ff;
    logic [2:0]  wcnt_ff;
    logic [7:0]  wbuf_ff [MAX_WR_BYTES];
    logic        busy_ff;
    logic [2:0]  sidx_ff;
    logic [7:0]  saddr_ff;
    logic [31:0] stime_ff;
    logic        buf_in_ready;
    logic [15:0] buf_out;

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic byte_done;
    logic load_next;
    logic send_crc;
    logic do_commit;
    logic push_word;

    assign start_det = scl_in && scl_q_ff && sda_q_ff && !sda_in;
    assign stop_det  = scl_in && scl_q_ff && !sda_q_ff && sda_in;
    assign scl_rise  = scl_in && !scl_q_ff;
    assign scl_fall  = !scl_in && scl_q_ff;
    assign byte_done = scl_fall && (bit_ff == BIT_LAST_DATA);
    assign load_next = scl_fall && (bit_ff == BIT_ACK) && (st_ff == S_RDATA);
    assign send_crc  = packet_error_check && (rem_ff == 8'h00); // R3 R22
    assign do_commit = stop_det && !busy_ff && (st_ff == S_WDATA) && (wcnt_ff != 3'h0); // R11 R13
    assign push_word = busy_ff && (sidx_ff < wcnt_ff);

    assign sda_out     = 1'b0;
    assign sda_oe      = sda_oe_ff;
    assign mem_rd_addr = addr_ff;
    assign store_busy  = busy_ff;
    assign store_addr  = buf_out[15:8];
    assign store_data  = buf_out[7:0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    // byte framing, acknowledge and transmit shifting
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff     <= S_IDLE;
            bit_ff    <= 4'h0;
            rx_ff     <= 8'h00;
            tx_ff     <= 8'hFF;
            sda_oe_ff <= 1'b0;
        end else if (busy_ff) begin
            st_ff     <= S_IDLE; // R14
            sda_oe_ff <= 1'b0; // R14
        end else if (start_det) begin
            st_ff     <= S_DEVADDR; // R12 R19
            bit_ff    <= BIT_ACK; // the scl fall after a start carries no data bit
            sda_oe_ff <= 1'b0;
        end else if (stop_det) begin
            st_ff     <= S_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (st_ff != S_IDLE && st_ff != S_WAIT) begin
            if (scl_rise && bit_ff < BIT_ACK) begin
                rx_ff <= {rx_ff[6:0], sda_in};
            end
            if (scl_rise && bit_ff == BIT_ACK && st_ff == S_RDATA && sda_in) begin
                st_ff <= S_WAIT; // R4
            end
            if (scl_fall) begin
                if (bit_ff < BIT_LAST_DATA) begin
                    bit_ff <= bit_ff + 4'h1;
                    if (st_ff == S_RDATA) begin
                        tx_ff     <= {tx_ff[6:0], 1'b1};
                        sda_oe_ff <= !tx_ff[6];
                    end
                end else if (bit_ff == BIT_LAST_DATA) begin
                    bit_ff    <= BIT_ACK;
                    sda_oe_ff <= 1'b0;
                    unique case (st_ff)
                        S_DEVADDR: begin
                            if (rx_ff[7:1] == DEV_ADDR) begin
                                sda_oe_ff <= 1'b1;
                                st_ff     <= rx_ff[0] ? S_RDATA : S_MADDR;
                            end else begin
                                st_ff <= S_WAIT;
                            end
                        end
                        S_MADDR: begin
                            sda_oe_ff <= 1'b1; // R10
                            st_ff     <= packet_error_check ? S_COUNT : S_WDATA; // R22
                        end
                        S_COUNT: begin
                            sda_oe_ff <= 1'b1;
                            st_ff     <= S_WDATA;
                        end
                        S_WDATA: begin
                            if (wcnt_ff < 3'(MAX_WR_BYTES)) begin
                                sda_oe_ff <= 1'b1; // R10 R18
                            end else begin
                                st_ff <= S_WAIT;
                            end
                        end
                        S_RDATA: begin
                            sda_oe_ff <= 1'b0;
                        end
                        default: begin
                            st_ff <= S_WAIT;
                        end
                    endcase
                end else begin
                    bit_ff <= 4'h0;
                    if (st_ff == S_RDATA) begin
                        tx_ff     <= send_crc ? crc_ff : mem_rd_data; // R3 R20
                        sda_oe_ff <= send_crc ? !crc_ff[7] : !mem_rd_data[7];
                    end else begin
                        sda_oe_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // start address, remaining count and running checksum
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= ADDR_RST;
            crc_ff  <= CRC_INIT;
            rem_ff  <= 8'h00;
        end else if (!busy_ff) begin
            if (byte_done && st_ff == S_MADDR) begin
                addr_ff <= rx_ff;
                crc_ff  <= crc8(CRC_INIT, rx_ff); // R2 R6
                rem_ff  <= 8'h00;
            end else if (byte_done && st_ff == S_COUNT) begin
                crc_ff <= crc8(crc_ff, rx_ff); // R2
                rem_ff <= rx_ff;
            end else if (load_next && !send_crc && !start_det && !stop_det) begin
                addr_ff <= addr_ff + 8'h01; // R20 R21
                crc_ff  <= crc8(crc_ff, mem_rd_data); // R2
                if (rem_ff != 8'h00) begin
                    rem_ff <= rem_ff - 8'h01;
                end
            end else if (do_commit) begin
                addr_ff <= addr_ff + {5'h00, wcnt_ff}; // R21
            end
        end
    end

    // received write bytes, dropped unless a stop ends a write of at most four data bytes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_ff <= 3'h0;
        end else if (busy_ff) begin
            if (!push_word && stime_ff == 32'h0) begin
                wcnt_ff <= 3'h0;
            end
        end else if (start_det) begin
            wcnt_ff <= 3'h0; // R12 R19
        end else if (stop_det && !do_commit) begin
            wcnt_ff <= 3'h0;
        end else if (byte_done && st_ff == S_WDATA && wcnt_ff < 3'(MAX_WR_BYTES)) begin
            wcnt_ff <= wcnt_ff + 3'h1; // R16
        end
    end

    always_ff @(posedge core_clk) begin
        if (!busy_ff && byte_done && st_ff == S_WDATA && wcnt_ff < 3'(MAX_WR_BYTES)) begin
            wbuf_ff[wcnt_ff[1:0]] <= rx_ff;
        end
    end

    // self-timed store cycle: drain bytes, then count down the store time; bus held off throughout
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff  <= 1'b0;
            sidx_ff  <= 3'h0;
            saddr_ff <= ADDR_RST;
            stime_ff <= 32'h0;
        end else if (do_commit) begin
            busy_ff  <= 1'b1; // R13
            sidx_ff  <= 3'h0;
            saddr_ff <= addr_ff;
            stime_ff <= 32'(STORE_CYCLES);
        end else if (busy_ff) begin
            if (push_word) begin
                if (buf_in_ready) begin
                    sidx_ff  <= sidx_ff + 3'h1;
                    saddr_ff <= saddr_ff + 8'h01;
                end
            end else if (stime_ff > 32'h1) begin
                stime_ff <= stime_ff - 32'h1;
            end else begin
                stime_ff <= 32'h0;
                busy_ff  <= 1'b0;
            end
        end
    end

    twin_buf #(
        .W (16)
    ) u_store_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (push_word),
        .in_ready  (buf_in_ready),
        .in_data   ({saddr_ff, wbuf_ff[sidx_ff[1:0]]}),
        .out_valid (store_valid),
        .out_ready (store_ready),
        .out_data  (buf_out)
    );

    property p_ack_maddr;
        @(posedge core_clk) disable iff (!rst_n)
        (byte_done && st_ff == S_MADDR && !busy_ff && !start_det && !stop_det) |=> sda_oe_ff;
    endproperty
    a_ack_maddr: assert property (p_ack_maddr) else $error("memory address not acked"); // R10

    property p_quiet_busy;
        @(posedge core_clk) disable iff (!rst_n)
        busy_ff |=> !sda_oe_ff && st_ff == S_IDLE;
    endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("bus answered while storing"); // R14

    property p_restart_drop;
        @(posedge core_clk) disable iff (!rst_n)
        (start_det && !busy_ff) |=> wcnt_ff == 3'h0 && st_ff == S_DEVADDR;
    endproperty
    a_restart_drop: assert property (p_restart_drop) else $error("write kept after restart"); // R12

    property p_commit;
        @(posedge core_clk) disable iff (!rst_n)
        do_commit |=> busy_ff && stime_ff == 32'(STORE_CYCLES) && saddr_ff == $past(addr_ff);
    endproperty
    a_commit: assert property (p_commit) else $error("store cycle not started"); // R13

    property p_max_bytes;
        @(posedge core_clk) disable iff (!rst_n)
        wcnt_ff <= 3'(MAX_WR_BYTES);
    endproperty
    a_max_bytes: assert property (p_max_bytes) else $error("write byte count overflow"); // R16

    property p_crc_byte;
        @(posedge core_clk) disable iff (!rst_n)
        (load_next && send_crc && !busy_ff && !start_det && !stop_det)
            |=> tx_ff == $past(crc_ff) && crc_ff == $past(crc_ff);
    endproperty
    a_crc_byte: assert property (p_crc_byte) else $error("checksum byte wrong"); // R3

    property p_addr_step;
        @(posedge core_clk) disable iff (!rst_n)
        (load_next && !send_crc && !busy_ff && !start_det && !stop_det)
            |=> addr_ff == $past(addr_ff) + 8'h01;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("read address not advanced"); // R21

    property p_count_only_checked;
        @(posedge core_clk) disable iff (!rst_n)
        (byte_done && st_ff == S_MADDR && !packet_error_check && !busy_ff && !start_det
            && !stop_det) |=> st_ff == S_WDATA;
    endproperty
    a_count_only_checked: assert property (p_count_only_checked) else $error("count byte in plain mode"); // R22

    property p_data_ack;
        @(posedge core_clk) disable iff (!rst_n)
        (byte_done && st_ff == S_WDATA && wcnt_ff < 3'(MAX_WR_BYTES) && !busy_ff && !start_det
            && !stop_det) |=> sda_oe_ff ##1 (wcnt_ff == $past(wcnt_ff, 2) + 3'h1);
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("write data byte not acked"); // R18
endmodule
`default_nettype wire

/* File: twowire_host_model.sv */
// host-side two-wire master model: bus clock, open-drain data, byte tasks
`timescale 1ns/1ps
`default_nettype none
module twowire_host_model #(
    parameter int HALF = 4
) (
    input  wire logic core_clk, // system clock
    output logic      scl,      // bus clock, host driven
    output logic      sda_rel,  // high = host releases data line
    input  wire logic sda       // resolved data line, pulled up
);
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // also serves as repeated start, since data is released while clock is low
    task automatic start();
        sda_rel = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_rel = 1'b0;
        tick(HALF);
        scl = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_rel = 1'b1;
        tick(HALF);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_rel = b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        r = sda;
        scl = 1'b0;
        tick(1);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(~ack, r);
    endtask
endmodule
`default_nettype wire

/* File: tb_mgmt_twowire_slave.sv */
// self-checking bench for the management two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tb_mgmt_twowire_slave;
    import twowire_pkg::*;
    localparam int STORE_N = 200;
    logic        core_clk;
    logic        rst_n;
    logic        scl;
    logic        sda_rel;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic        packet_error_check;
    logic [7:0]  mem_rd_addr;
    logic [7:0]  mem_rd_data;
    logic        store_valid;
    logic        store_ready;
    logic [7:0]  store_addr;
    logic [7:0]  store_data;
    logic        store_busy;
    logic [7:0]  mem [256];
    logic [7:0]  exp_mem [256];
    logic [15:0] got_q [$];
    int          num_errors;
    int          compares;
    // pull-up: line is high unless someone pulls it low
    assign sda = sda_rel & ~sda_oe;
    assign mem_rd_data = mem[mem_rd_addr];
    mgmt_twowire_slave #(.STORE_CYCLES(STORE_N)) u_mgmt_twowire_slave (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .packet_error_check(packet_error_check),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .store_valid(store_valid), .store_ready(store_ready),
        .store_addr(store_addr), .store_data(store_data), .store_busy(store_busy)
    );
    twowire_host_model u_host (
        .core_clk(core_clk), .scl(scl), .sda_rel(sda_rel), .sda(sda)
    );
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (store_valid && store_ready) begin
            mem[store_addr] <= store_data;
            got_q.push_back({store_addr, store_data});
        end
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int k = 0; k < 8; k++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        u_host.wbyte(d, a);
        chk(16'(a), 16'(exp_ack));
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 2 * STORE_N + 100 && store_busy !== 1'b0; n++) u_host.tick(1);
        chk(16'(store_busy), 16'h0000);
    endtask
    task automatic t_write_single();
        got_q.delete();
        u_host.start();
        send(8'hA0, 1'b1);
        send(8'h10, 1'b1);
        send(8'h5A, 1'b1);
        u_host.tick(20);
        chk(16'({store_busy, store_valid}), 16'h0000);
        u_host.stop();
        exp_mem[8'h10] = 8'h5A;
        chk(16'(store_busy), 16'h0001);
        u_host.start();
        send(8'hA0, 1'b0);
        u_host.stop();
        wait_idle();
        chk(16'(got_q.size()), 16'h0001);
        chk(got_q[0], 16'h105A);
        chk(16'(mem_rd_addr), 16'h0011);
        chk(16'(sda_out), 16'h0000);
        $display("t_write_single done");
    endtask
    task automatic t_write_burst();
        got_q.delete();
        store_ready = 1'b0;
        u_host.start();
        send(8'hA0, 1'b1);
        send(8'h20, 1'b1);
        for (int i = 0; i < MAX_WR_BYTES; i++) send(8'(8'hC0 + i), 1'b1);
        u_host.stop();
        u_host.tick(30);
        chk(16'({store_valid, store_busy}), 16'h0003);
        chk(16'(got_q.size()), 16'h0000);
        store_ready = 1'b1;
        wait_idle();
        chk(16'(got_q.size()), 16'(MAX_WR_BYTES));
        for (int i = 0; i < MAX_WR_BYTES; i++) begin
            chk(got_q[i], {8'(8'h20 + i), 8'(8'hC0 + i)});
            exp_mem[8'(8'h20 + i)] = 8'(8'hC0 + i);
        end
        $display("t_write_burst done");
    endtask
    task automatic t_write_abort();
        got_q.delete();
        u_host.start();
        send(8'hA0, 1'b1);
        send(8'h30, 1'b1);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        u_host.start();
        u_host.stop();
        u_host.tick(20);
        chk(16'({store_busy, store_valid}), 16'h0000);
        chk(16'(got_q.size()), 16'h0000);
        $display("t_write_abort done");
    endtask
    task automatic t_read_checked(input logic [7:0] ma, input logic [7:0] cnt);
        logic [7:0] d;
        logic [7:0] crc;
        packet_error_check = 1'b1;
        crc = crc8(crc8(CRC_INIT, ma), cnt);
        u_host.start();
        send(8'hA0, 1'b1);
        send(ma, 1'b1);
        send(cnt, 1'b1);
        u_host.start();
        send(8'hA1, 1'b1);
        for (int i = 0; i < cnt; i++) begin
            u_host.rbyte(1'b1, d);
            chk(16'(d), 16'(exp_mem[8'(ma + i)]));
            crc = crc8(crc, exp_mem[8'(ma + i)]);
        end
        u_host.rbyte(1'b0, d);
        chk(16'(d), 16'(crc));
        u_host.stop();
        packet_error_check = 1'b0;
        $display("t_read_checked done");
    endtask
    task automatic t_read_plain(input logic [7:0] ma);
        logic [7:0] d;
        u_host.start();
        send(8'hA0, 1'b1);
        send(ma, 1'b1);
        u_host.start();
        send(8'hA1, 1'b1);
        u_host.rbyte(1'b1, d);
        chk(16'(d), 16'(exp_mem[ma]));
        u_host.rbyte(1'b0, d);
        chk(16'(d), 16'(exp_mem[8'(ma + 1)]));
        u_host.stop();
        $display("t_read_plain done");
    endtask
    initial begin
        rst_n       = 1'b0;
        packet_error_check = 1'b0;
        store_ready = 1'b1;
        num_errors  = 0;
        compares    = 0;
        for (int i = 0; i < 256; i++) begin
            mem[i]     = 8'(i * 29 + 7);
            exp_mem[i] = 8'(i * 29 + 7);
        end
        repeat (10) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        u_host.tick(4);
        t_write_single();
        t_write_burst();
        t_write_abort();
        t_read_checked(8'h20, 8'h04);
        t_read_checked(8'h30, 8'h01);
        t_read_checked(8'h40, 8'h80);
        t_read_plain(8'h0F);
        close_out();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
